// ===== hdl/tmrtw_top.sv
// Timer block: up-counter, overflow counter, flags, masks, latching windows and events
//
// Notes on behaviour
// - Long compare two flag sets when overflow equals compare two and counter hits compare two.
// - Long compare one flag sets when overflow equals compare one and counter hits compare one.
// - Bits 5 and 4 set when the overflow counter reaches overflow compare two and one.
// - The overflow counter wraps to zero instead of reaching its period, setting bit 3.
// - Bits 2 and 1 set when the counter reaches compare two and compare one.
// - The counter wraps to zero instead of reaching its period, setting bit 0.
// - Latch mode 0 latches counter high on counter low read and overflow mid and top on overflow low read.
// - Latch mode 1 latches counter high and whole overflow counter on counter low read.
// - Sync bit 0 starts and stops at once, sync bit 1 at the next slow clock rising edge.
// - Writing run 1 starts the timer, 0 stops it, and run reads back as written.
// - Event two source is chosen by event config bits 7:4.
// - Event one source by bits 3:0; codes 0 to 5 pick flag bits 0 to 5, codes 8 and 9 pick long compares, others give no event.
// - Selector codes 0 to 4 pick counter, capture, period, compare one and compare two.
// - A synchronised start enters running 86 cycles after the slow edge is seen high.
`timescale 1ns/1ps
module tmrtw_top (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire tmrtw_pkg::tmrtw_bus_t bus,
  input  wire logic                 slow_clk,
  output logic [7:0]                rdata,
  output logic                      irq,
  output logic                      event_pulse_one,
  output logic                      event_pulse_two
);
  logic [7:0]             flags_r;
  logic [7:0]             masks_r;
  logic [7:0]             evtcfg_r;
  logic                   run_r;
  logic                   sync_r;
  logic                   latch_mode_r;
  logic [2:0]             cnt_sel_r;
  logic [2:0]             ovf_sel_r;
  logic [15:0]            up_counter_r;
  logic [23:0]            overflow_counter_r;
  logic [15:0]            counter_period_r;
  logic [15:0]            counter_compare_one_r;
  logic [15:0]            counter_compare_two_r;
  logic [23:0]            overflow_period_r;
  logic [23:0]            overflow_compare_one_r;
  logic [23:0]            overflow_compare_two_r;
  logic [15:0]            capture_r;
  logic [23:0]            ovf_capture_r;
  logic [7:0]             cnt_hi_latch_r;
  logic [23:0]            ovf_latch_r;
  tmrtw_pkg::tmrtw_state_t state_r;
  logic [6:0]             wait_cnt_r;
  logic                   slow_sync;
  logic                   slow_prev_r;
  logic                   slow_rise;
  logic                   running;
  logic [15:0]            cnt_nxt;
  logic [23:0]            ovf_nxt;
  logic [7:0]             ev;
  logic                   ovf_step;
  logic [23:0]            cnt_view;
  logic [23:0]            ovf_view;

  tmrtw_sync3 u_slow_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    (slow_clk),
    .dout   (slow_sync)
  );

  // Reads one field of a 16-bit or 24-bit window register set
  function automatic logic [23:0] pick(input logic [2:0] sel, input logic [23:0] cnt,
                                        input logic [23:0] cap, input logic [23:0] per,
                                        input logic [23:0] c1, input logic [23:0] c2);
    case (sel)
      tmrtw_pkg::SEL_COUNT: pick = cnt;
      tmrtw_pkg::SEL_CAPT:  pick = cap;
      tmrtw_pkg::SEL_PER:   pick = per;
      tmrtw_pkg::SEL_CMP1:  pick = c1;
      tmrtw_pkg::SEL_CMP2:  pick = c2;
      default:              pick = 24'h00_0000;
    endcase
  endfunction : pick

  // Selects an event from its four-bit code
  function automatic logic evsel(input logic [3:0] code, input logic [7:0] e);
    if (code <= 4'h5) begin
      evsel = e[code[2:0]];
    end else if (code == tmrtw_pkg::EVT_LONG1) begin
      evsel = e[tmrtw_pkg::FLG_LONG1];
    end else if (code == tmrtw_pkg::EVT_LONG2) begin
      evsel = e[tmrtw_pkg::FLG_LONG2];
    end else begin
      evsel = 1'b0;
    end
  endfunction : evsel

  // Window contents seen by the read port
  always_comb begin
    cnt_view = pick(cnt_sel_r, {8'h00, up_counter_r}, {8'h00, capture_r},
                    {8'h00, counter_period_r}, {8'h00, counter_compare_one_r},
                    {8'h00, counter_compare_two_r});
    ovf_view = pick(ovf_sel_r, ovf_latch_r, ovf_capture_r, overflow_period_r,
                    overflow_compare_one_r, overflow_compare_two_r);
  end

  assign slow_rise = slow_sync & ~slow_prev_r;
  assign running   = (state_r == tmrtw_pkg::TMRTW_RUN);

  // Counting and event detection
  always_comb begin
    ev       = 8'h00;
    cnt_nxt  = up_counter_r + 16'h0001;
    ovf_nxt  = overflow_counter_r;
    ovf_step = 1'b0;
    if (running) begin
      if (cnt_nxt == counter_period_r) begin
        cnt_nxt                 = 16'h0000;
        ovf_step                = 1'b1;
        ev[tmrtw_pkg::FLG_PER]  = 1'b1;
      end
      ev[tmrtw_pkg::FLG_CMP1] = (cnt_nxt == counter_compare_one_r);
      ev[tmrtw_pkg::FLG_CMP2] = (cnt_nxt == counter_compare_two_r);
      if (ovf_step) begin
        ovf_nxt = overflow_counter_r + 24'h00_0001;
        if (ovf_nxt == overflow_period_r) begin
          ovf_nxt                    = 24'h00_0000;
          ev[tmrtw_pkg::FLG_OVF_PER] = 1'b1;
        end
        ev[tmrtw_pkg::FLG_OVF_CMP1] = (ovf_nxt == overflow_compare_one_r);
        ev[tmrtw_pkg::FLG_OVF_CMP2] = (ovf_nxt == overflow_compare_two_r);
      end
      ev[tmrtw_pkg::FLG_LONG1] = ev[tmrtw_pkg::FLG_CMP1]
                                 & (ovf_nxt == overflow_compare_one_r);
      ev[tmrtw_pkg::FLG_LONG2] = ev[tmrtw_pkg::FLG_CMP2]
                                 & (ovf_nxt == overflow_compare_two_r);
    end else begin
      cnt_nxt = up_counter_r;
    end
  end

  // Run state machine
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r     <= tmrtw_pkg::TMRTW_IDLE;
      wait_cnt_r  <= 7'h00;
      slow_prev_r <= 1'b0;
    end else begin
      slow_prev_r <= slow_sync;
      case (state_r)
        tmrtw_pkg::TMRTW_IDLE: begin
          if (run_r) begin
            state_r <= sync_r ? tmrtw_pkg::TMRTW_WAIT_EDGE : tmrtw_pkg::TMRTW_RUN;
          end
        end
        tmrtw_pkg::TMRTW_WAIT_EDGE: begin
          if (!run_r) begin
            state_r <= tmrtw_pkg::TMRTW_IDLE;
          end else if (slow_rise) begin
            state_r    <= tmrtw_pkg::TMRTW_LOADING;
            wait_cnt_r <= tmrtw_pkg::SYNC_WAIT;
          end
        end
        tmrtw_pkg::TMRTW_LOADING: begin
          if (wait_cnt_r == 7'h01) begin
            state_r <= tmrtw_pkg::TMRTW_RUN;
          end
          wait_cnt_r <= wait_cnt_r - 7'h01;
        end
        tmrtw_pkg::TMRTW_RUN: begin
          if (!run_r && (!sync_r || slow_rise)) begin
            state_r <= tmrtw_pkg::TMRTW_IDLE;
          end
        end
        default: state_r <= tmrtw_pkg::TMRTW_IDLE;
      endcase
    end
  end

  // Control and configuration registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_r        <= 1'b0;
      sync_r       <= 1'b0;
      latch_mode_r <= 1'b0;
      masks_r      <= tmrtw_pkg::RST_BYTE;
      evtcfg_r     <= tmrtw_pkg::RST_BYTE;
      cnt_sel_r    <= 3'h0;
      ovf_sel_r    <= 3'h0;
    end else if (bus.wr) begin
      case (bus.addr)
        tmrtw_pkg::ADDR_CTRL: begin
          run_r        <= bus.wdata[tmrtw_pkg::CTRL_RUN];
          sync_r       <= bus.wdata[tmrtw_pkg::CTRL_SYNC];
          latch_mode_r <= bus.wdata[tmrtw_pkg::CTRL_LATCH];
        end
        tmrtw_pkg::ADDR_MASKS:  masks_r  <= bus.wdata;
        tmrtw_pkg::ADDR_EVTCFG: evtcfg_r <= bus.wdata;
        tmrtw_pkg::ADDR_SEL: begin
          cnt_sel_r <= bus.wdata[2:0];
          ovf_sel_r <= bus.wdata[6:4];
        end
        default: ;
      endcase
    end
  end

  // Counters and their window registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      up_counter_r           <= tmrtw_pkg::RST_CNT;
      overflow_counter_r     <= tmrtw_pkg::RST_OVF;
      counter_period_r       <= tmrtw_pkg::RST_CNT;
      counter_compare_one_r  <= tmrtw_pkg::RST_CNT;
      counter_compare_two_r  <= tmrtw_pkg::RST_CNT;
      overflow_period_r      <= tmrtw_pkg::RST_OVF;
      overflow_compare_one_r <= tmrtw_pkg::RST_OVF;
      overflow_compare_two_r <= tmrtw_pkg::RST_OVF;
      capture_r              <= tmrtw_pkg::RST_CNT;
      ovf_capture_r          <= tmrtw_pkg::RST_OVF;
    end else begin
      up_counter_r       <= cnt_nxt;
      overflow_counter_r <= ovf_nxt;
      if (running && !run_r && (!sync_r || slow_rise)) begin
        capture_r     <= up_counter_r;
        ovf_capture_r <= overflow_counter_r;
      end
      if (bus.wr) begin
        case ({bus.addr, cnt_sel_r})
          {tmrtw_pkg::ADDR_CNT_LO, tmrtw_pkg::SEL_COUNT}: up_counter_r[7:0]  <= bus.wdata;
          {tmrtw_pkg::ADDR_CNT_HI, tmrtw_pkg::SEL_COUNT}: up_counter_r[15:8] <= bus.wdata;
          {tmrtw_pkg::ADDR_CNT_LO, tmrtw_pkg::SEL_PER}:  counter_period_r[7:0]  <= bus.wdata;
          {tmrtw_pkg::ADDR_CNT_HI, tmrtw_pkg::SEL_PER}:  counter_period_r[15:8] <= bus.wdata;
          {tmrtw_pkg::ADDR_CNT_LO, tmrtw_pkg::SEL_CMP1}: counter_compare_one_r[7:0] <= bus.wdata;
          {tmrtw_pkg::ADDR_CNT_HI, tmrtw_pkg::SEL_CMP1}:
            counter_compare_one_r[15:8] <= bus.wdata;
          {tmrtw_pkg::ADDR_CNT_LO, tmrtw_pkg::SEL_CMP2}: counter_compare_two_r[7:0] <= bus.wdata;
          {tmrtw_pkg::ADDR_CNT_HI, tmrtw_pkg::SEL_CMP2}:
            counter_compare_two_r[15:8] <= bus.wdata;
          default: ;
        endcase
        if (bus.addr >= tmrtw_pkg::ADDR_OVF_LO && bus.addr <= tmrtw_pkg::ADDR_OVF_TOP) begin
          case (ovf_sel_r)
            tmrtw_pkg::SEL_COUNT:
              overflow_counter_r[8*(bus.addr-tmrtw_pkg::ADDR_OVF_LO) +: 8] <= bus.wdata;
            tmrtw_pkg::SEL_PER:
              overflow_period_r[8*(bus.addr-tmrtw_pkg::ADDR_OVF_LO) +: 8] <= bus.wdata;
            tmrtw_pkg::SEL_CMP1:
              overflow_compare_one_r[8*(bus.addr-tmrtw_pkg::ADDR_OVF_LO) +: 8] <= bus.wdata;
            tmrtw_pkg::SEL_CMP2:
              overflow_compare_two_r[8*(bus.addr-tmrtw_pkg::ADDR_OVF_LO) +: 8] <= bus.wdata;
            default: ;
          endcase
        end
      end
    end
  end

  // Coherent read latches
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_hi_latch_r <= tmrtw_pkg::RST_BYTE;
      ovf_latch_r    <= tmrtw_pkg::RST_OVF;
    end else if (bus.rd) begin
      if (bus.addr == tmrtw_pkg::ADDR_CNT_LO && cnt_sel_r == tmrtw_pkg::SEL_COUNT) begin
        cnt_hi_latch_r <= up_counter_r[15:8];
        if (latch_mode_r) begin
          ovf_latch_r <= overflow_counter_r;
        end
      end
      if (bus.addr == tmrtw_pkg::ADDR_OVF_LO && ovf_sel_r == tmrtw_pkg::SEL_COUNT
          && !latch_mode_r) begin
        ovf_latch_r[23:8] <= overflow_counter_r[23:8];
      end
    end
  end

  // Interrupt flags; a hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags_r <= tmrtw_pkg::RST_BYTE;
    end else if (bus.wr && bus.addr == tmrtw_pkg::ADDR_FLAGS) begin
      flags_r <= (flags_r & bus.wdata) | ev;
    end else begin
      flags_r <= flags_r | ev;
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq             <= 1'b0;
      event_pulse_one <= 1'b0;
      event_pulse_two <= 1'b0;
      rdata           <= tmrtw_pkg::RST_BYTE;
    end else begin
      irq             <= |(flags_r & masks_r);
      event_pulse_one <= evsel(evtcfg_r[3:0], ev);
      event_pulse_two <= evsel(evtcfg_r[7:4], ev);
      rdata           <= 8'h00;
      if (bus.rd) begin
        case (bus.addr)
          tmrtw_pkg::ADDR_CTRL:   rdata <= {4'h0, latch_mode_r, running, sync_r, run_r};
          tmrtw_pkg::ADDR_FLAGS:  rdata <= flags_r;
          tmrtw_pkg::ADDR_MASKS:  rdata <= masks_r;
          tmrtw_pkg::ADDR_EVTCFG: rdata <= evtcfg_r;
          tmrtw_pkg::ADDR_SEL:    rdata <= {1'b0, ovf_sel_r, 1'b0, cnt_sel_r};
          tmrtw_pkg::ADDR_CNT_LO: rdata <= cnt_view[7:0];
          tmrtw_pkg::ADDR_CNT_HI:
            rdata <= (cnt_sel_r == tmrtw_pkg::SEL_COUNT) ? cnt_hi_latch_r : cnt_view[15:8];
          tmrtw_pkg::ADDR_OVF_LO:
            rdata <= (ovf_sel_r != tmrtw_pkg::SEL_COUNT) ? ovf_view[7:0] :
                     latch_mode_r ? ovf_latch_r[7:0] : overflow_counter_r[7:0];
          tmrtw_pkg::ADDR_OVF_MID: rdata <= ovf_view[15:8];
          tmrtw_pkg::ADDR_OVF_TOP: rdata <= ovf_view[23:16];
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule : tmrtw_top

// ===== pkg/tmrtw_pkg.sv
// Package: register map, field positions, reset values and types of the timer block
package tmrtw_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h94;
  localparam logic [7:0] ADDR_EVTCFG  = 8'h9c;
  localparam logic [7:0] ADDR_FLAGS   = 8'ha1;
  localparam logic [7:0] ADDR_CNT_LO  = 8'ha2;
  localparam logic [7:0] ADDR_CNT_HI  = 8'ha3;
  localparam logic [7:0] ADDR_OVF_LO  = 8'ha4;
  localparam logic [7:0] ADDR_OVF_MID = 8'ha5;
  localparam logic [7:0] ADDR_OVF_TOP = 8'ha6;
  localparam logic [7:0] ADDR_MASKS   = 8'ha7;
  localparam logic [7:0] ADDR_SEL     = 8'hc3;

  localparam int CTRL_RUN   = 0;
  localparam int CTRL_SYNC  = 1;
  localparam int CTRL_STATE = 2;
  localparam int CTRL_LATCH = 3;

  localparam int FLG_PER      = 0;
  localparam int FLG_CMP1     = 1;
  localparam int FLG_CMP2     = 2;
  localparam int FLG_OVF_PER  = 3;
  localparam int FLG_OVF_CMP1 = 4;
  localparam int FLG_OVF_CMP2 = 5;
  localparam int FLG_LONG1    = 6;
  localparam int FLG_LONG2    = 7;

  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_CNT  = 16'h0000;
  localparam logic [23:0] RST_OVF  = 24'h00_0000;

  // Window selector codes
  localparam logic [2:0] SEL_COUNT = 3'h0;
  localparam logic [2:0] SEL_CAPT  = 3'h1;
  localparam logic [2:0] SEL_PER   = 3'h2;
  localparam logic [2:0] SEL_CMP1  = 3'h3;
  localparam logic [2:0] SEL_CMP2  = 3'h4;

  // Event source codes
  localparam logic [3:0] EVT_LONG1 = 4'h8;
  localparam logic [3:0] EVT_LONG2 = 4'h9;

  // Synchronised start overhead in fast clock cycles
  localparam int SYNC_OVERHEAD_CYC = 86;
  localparam logic [6:0] SYNC_WAIT = 7'(SYNC_OVERHEAD_CYC - 1);

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmrtw_bus_t;

  typedef enum {TMRTW_IDLE, TMRTW_WAIT_EDGE, TMRTW_LOADING, TMRTW_RUN} tmrtw_state_t;
endpackage : tmrtw_pkg

// ===== hdl/tmrtw_sync3.sv
// Three-stage synchroniser; output changes once stages two and three agree
`timescale 1ns/1ps
module tmrtw_sync3 (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule : tmrtw_sync3

// ===== bench/tmrtw_sva.sv
// Checker: port-level properties of the timer block
`timescale 1ns/1ps
module tmrtw_sva (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire tmrtw_pkg::tmrtw_bus_t bus,
  input wire logic                  slow_clk,
  input wire logic [7:0]            rdata,
  input wire logic                  irq,
  input wire logic                  event_pulse_one,
  input wire logic                  event_pulse_two
);
  logic [7:0] ctrl_m;
  logic [7:0] evt_m;
  logic [7:0] mask_m;
  logic [2:0] quiet_m;
  wire        rd_c = bus.rd && bus.addr == tmrtw_pkg::ADDR_CTRL;
  wire        wr_c = bus.wr && bus.addr == tmrtw_pkg::ADDR_CTRL;
  wire        none1 = evt_m[3:0] inside {4'h6, 4'h7, [4'ha:4'hf]};
  wire        none2 = evt_m[7:4] inside {4'h6, 4'h7, [4'ha:4'hf]};

  // Mirrors of the control, event config and mask registers
  always_ff @(posedge clk) begin
    if (!resetn) ctrl_m <= 8'h00;
    else if (wr_c) ctrl_m <= bus.wdata;
  end
  always_ff @(posedge clk) begin
    if (!resetn) evt_m <= 8'h00;
    else if (bus.wr && bus.addr == tmrtw_pkg::ADDR_EVTCFG) evt_m <= bus.wdata;
  end
  always_ff @(posedge clk) begin
    if (!resetn) mask_m <= 8'h00;
    else if (bus.wr && bus.addr == tmrtw_pkg::ADDR_MASKS) mask_m <= bus.wdata;
  end
  // Cycles since the last control write, saturating
  always_ff @(posedge clk) begin
    if (!resetn || wr_c) quiet_m <= 3'h0;
    else if (quiet_m != 3'h7) quiet_m <= quiet_m + 3'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_ctrl_readback: assert property (
    rd_c |=> (rdata & 8'hfb) == ($past(ctrl_m) & 8'h0b)) else $error("control readback wrong");
  a_state_follows: assert property (
    rd_c && quiet_m == 3'h7 && !ctrl_m[1] |=> rdata[2] == rdata[0])
    else $error("running state does not follow run bit");
  a_mask_readback: assert property (
    bus.rd && bus.addr == tmrtw_pkg::ADDR_MASKS |=> rdata == $past(mask_m))
    else $error("mask readback wrong");
  a_evtcfg_readback: assert property (
    bus.rd && bus.addr == tmrtw_pkg::ADDR_EVTCFG |=> rdata == $past(evt_m))
    else $error("event config readback wrong");
  a_irq_masked_off: assert property (
    mask_m == 8'h00 && $past(mask_m) == 8'h00 |-> !irq) else $error("irq with all masks off");
  a_irq_reset_low: assert property (
    disable iff (1'b0) !resetn |=> !irq) else $error("irq after reset");
  a_evt_one_none: assert property (
    none1 && $past(none1) |-> !event_pulse_one) else $error("pulse one on a silent code");
  a_evt_two_none: assert property (
    none2 && $past(none2) |-> !event_pulse_two) else $error("pulse two on a silent code");

  c_irq: cover property ($rose(irq));
  c_evt_one: cover property (event_pulse_one);
  c_evt_two: cover property (event_pulse_two);
  c_running: cover property (rd_c ##1 rdata[2]);
endmodule : tmrtw_sva

// ===== bench/tmrtw_top_tb.sv
// Testbench: register-level tests of the timer block
`timescale 1ns/1ps
module tmrtw_top_tb;
  logic                  clk;
  logic                  resetn;
  tmrtw_pkg::tmrtw_bus_t bus;
  logic                  slow_clk;
  logic [7:0]            rdata;
  logic                  irq;
  logic                  event_pulse_one;
  logic                  event_pulse_two;
  logic [7:0]            rv;
  int                    n_mismatch;
  int                    compares;
  int                    n1;
  int                    n2;
  // Selector in the high byte, low window byte in the low byte
  logic [15:0]           cfg [6] = '{16'h0210, 16'h0304, 16'h0408, 16'h2003, 16'h3001, 16'h4002};
  logic [3:0]            codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                        4'h8, 4'h9, 4'ha, 4'hf};
  logic [7:0]            exp_n [12] = '{8'h09, 8'h09, 8'h09, 8'h03, 8'h03, 8'h03, 8'h00,
                                        8'h00, 8'h03, 8'h03, 8'h00, 8'h00};

  tmrtw_top tmrtw_top_inst (.clk(clk), .resetn(resetn), .bus(bus), .slow_clk(slow_clk),
    .rdata(rdata), .irq(irq), .event_pulse_one(event_pulse_one),
    .event_pulse_two(event_pulse_two));

  task automatic step();
    @(posedge clk) #5;
  endtask : step
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step();
    bus = '0;
    step();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step();
    rv = rdata;
    bus = '0;
    step();
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(rv, exp);
  endtask : rchk
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    bus = '0;
    slow_clk = 1'b0;
    n_mismatch = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    #5 resetn = 1'b1;
    rchk(tmrtw_pkg::ADDR_CTRL, 8'h00);
    rchk(tmrtw_pkg::ADDR_EVTCFG, 8'h00);
    rchk(tmrtw_pkg::ADDR_FLAGS, 8'h00);
    rchk(tmrtw_pkg::ADDR_MASKS, 8'h00);
    wr(tmrtw_pkg::ADDR_MASKS, 8'ha5);
    rchk(tmrtw_pkg::ADDR_MASKS, 8'ha5);
    wr(tmrtw_pkg::ADDR_CTRL, 8'hfe);
    rchk(tmrtw_pkg::ADDR_CTRL, 8'h0a);
    wr(tmrtw_pkg::ADDR_CTRL, 8'h00);
    // Period 16, compares 4 and 8; overflow period 3, compares 1 and 2
    foreach (cfg[i]) begin
      wr(tmrtw_pkg::ADDR_SEL, cfg[i][15:8]);
      wr(cfg[i][14:12] != 3'h0 ? tmrtw_pkg::ADDR_OVF_LO : tmrtw_pkg::ADDR_CNT_LO, cfg[i][7:0]);
    end
    wr(tmrtw_pkg::ADDR_SEL, 8'h44);
    rchk(tmrtw_pkg::ADDR_CNT_LO, 8'h08);
    rchk(tmrtw_pkg::ADDR_OVF_LO, 8'h02);
    wr(tmrtw_pkg::ADDR_SEL, 8'h00);
    wr(tmrtw_pkg::ADDR_MASKS, 8'hff);
    wr(tmrtw_pkg::ADDR_CTRL, 8'h01);
    rchk(tmrtw_pkg::ADDR_CTRL, 8'h05);
    // Any 144 running cycles hold three whole overflow periods
    foreach (codes[i]) begin
      wr(tmrtw_pkg::ADDR_EVTCFG, {codes[i], codes[i]});
      repeat (4) step();
      n1 = 0;
      n2 = 0;
      repeat (144) begin
        step();
        n1 += event_pulse_one;
        n2 += event_pulse_two;
      end
      check(8'(n1), exp_n[i]);
      check(8'(n2), exp_n[i]);
    end
    check({7'h0, irq}, 8'h01);
    wr(tmrtw_pkg::ADDR_CTRL, 8'h00);
    repeat (4) step();
    rchk(tmrtw_pkg::ADDR_CTRL, 8'h00);
    rchk(tmrtw_pkg::ADDR_FLAGS, 8'hff);
    wr(tmrtw_pkg::ADDR_MASKS, 8'h00);
    check({7'h0, irq}, 8'h00);
    wr(tmrtw_pkg::ADDR_FLAGS, 8'hfe);
    rchk(tmrtw_pkg::ADDR_FLAGS, 8'hfe);
    wr(tmrtw_pkg::ADDR_MASKS, 8'h01);
    check({7'h0, irq}, 8'h00);
    wr(tmrtw_pkg::ADDR_MASKS, 8'h02);
    check({7'h0, irq}, 8'h01);
    wr(tmrtw_pkg::ADDR_FLAGS, 8'h00);
    wr(tmrtw_pkg::ADDR_FLAGS, 8'hff);
    rchk(tmrtw_pkg::ADDR_FLAGS, 8'h00);
    // Latched bytes must not follow later writes
    wr(tmrtw_pkg::ADDR_CNT_HI, 8'h00);
    rd(tmrtw_pkg::ADDR_CNT_LO);
    wr(tmrtw_pkg::ADDR_CNT_HI, 8'h3c);
    rchk(tmrtw_pkg::ADDR_CNT_HI, 8'h00);
    rd(tmrtw_pkg::ADDR_CNT_LO);
    rchk(tmrtw_pkg::ADDR_CNT_HI, 8'h3c);
    wr(tmrtw_pkg::ADDR_OVF_MID, 8'h00);
    rd(tmrtw_pkg::ADDR_OVF_LO);
    wr(tmrtw_pkg::ADDR_OVF_MID, 8'h5c);
    rchk(tmrtw_pkg::ADDR_OVF_MID, 8'h00);
    wr(tmrtw_pkg::ADDR_CTRL, 8'h08);
    rd(tmrtw_pkg::ADDR_CNT_LO);
    wr(tmrtw_pkg::ADDR_OVF_MID, 8'h11);
    rchk(tmrtw_pkg::ADDR_OVF_MID, 8'h5c);
    // Start and stop wait for the slow clock edge
    wr(tmrtw_pkg::ADDR_CTRL, 8'h03);
    repeat (20) step();
    rchk(tmrtw_pkg::ADDR_CTRL, 8'h03);
    slow_clk = 1'b1;
    repeat (80) step();
    rchk(tmrtw_pkg::ADDR_CTRL, 8'h03);
    repeat (14) step();
    rchk(tmrtw_pkg::ADDR_CTRL, 8'h07);
    wr(tmrtw_pkg::ADDR_CTRL, 8'h02);
    repeat (20) step();
    rchk(tmrtw_pkg::ADDR_CTRL, 8'h06);
    slow_clk = 1'b0;
    repeat (10) step();
    slow_clk = 1'b1;
    repeat (10) step();
    rchk(tmrtw_pkg::ADDR_CTRL, 8'h02);
    close_out();
  end
endmodule : tmrtw_top_tb

bind tmrtw_top tmrtw_sva tmrtw_sva_inst (.clk(clk), .resetn(resetn), .bus(bus),
  .slow_clk(slow_clk), .rdata(rdata), .irq(irq), .event_pulse_one(event_pulse_one),
  .event_pulse_two(event_pulse_two));
